// [core/pms_power_mode_selector.sv]
// Purpose: Power mode controller: run, low-power run, wait, low-power wait, two stops
// Assumes: CPU strobes and events are one-cycle pulses on ref_clk; wake pins are async
// Notes:   APB slave with zero wait states; read data is captured in the setup cycle
// What this block does
// - Debug enable or both low-voltage bits keep full run, regulator full on.
// - Low-power run only with all bits right; bypass clock, regulator standby.
// - Wait stops CPU clock; peripherals full speed, or slow in low-power wait.
// - Debug or both low-voltage bits turn a partial powerdown stop into retention.
// - Retention: debug clock per debug bit, regulator raised or standby, refclocks optional.
// - Stop from run with proper bits enters partial powerdown stop.
// - Partial powerdown removes power from all but timer and display driver.
// - Debug enable is written only over the background debug link.
// - Partial powerdown exits only on wake pins low or timer interrupt.
// - Any enabled interrupt wakes retention stop, wait and low-power wait.
// - Partial powerdown exit restarts as from power-on, back to run.
// - Wake-to-full-run clear: low-power wakes return to low-power run.
// - Wake-to-full-run set: interrupts in low-power modes go to full run.
// - Wait from run; interrupt or reset returns from wait to run.
// - Retention stop returns to run on reset or qualifying interrupt.
// - Stop from run enters retention when partial powerdown is not allowed.
// - Stop with stop disabled forces an illegal-opcode reset, no stop.
// - Partial powerdown select and low-power request block each other.
// - Recovery flag and pin latches hold until acknowledge written with 1.
// - Stop in low-power run enters retention stop.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pms_regs.svh"
module pms_power_mode_selector (
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire logic [`PMS_ADDR_W-1:0] paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   waitStrobe,
  input  wire logic                   stopStrobe,
  input  wire logic                   irqEvent,
  input  wire logic                   cpuResetEvent,
  input  wire logic                   todIrq,
  input  wire logic                   dbgLinkWrite,
  input  wire logic                   dbgLinkEnable,
  input  wire logic                   wakeResetPinN,
  input  wire logic                   wakeIrqPinN,
  input  wire logic [2:0]             clkGenStopEn,
  output pms_pkg::pms_mode_t          modeState,
  output pms_pkg::pms_regu_t          regState,
  output logic                        cpuClkEn,
  output logic                        periphClkEn,
  output logic                        periphLowSpeed,
  output logic                        clkGenBypassLp,
  output logic                        debugClkEn,
  output logic      [2:0]             refClkKeep,
  output logic                        domainPowerOff,
  output logic                        ioLatchHold,
  output logic                        recoveryFlag,
  output logic                        illegalOpReset,
  output logic                        porRestart
);
  import pms_pkg::*;

  pms_state_t st_reg;
  pms_state_t st_next;
  pms_cfg_if  cfgBus ();

  logic wrAcc;
  logic rdSetup;
  logic ackWrite;
  logic pinWake;
  logic mapped;

  assign cfgBus.dbgEn = st_reg.dbg;
  assign cfgBus.lowvolt_detect_enable  = st_reg.lowvolt_detect_enable;
  assign cfgBus.lowvolt_detect_in_stop = st_reg.lowvolt_detect_in_stop;
  assign cfgBus.low_power_run_request   = st_reg.low_power_run_request;
  assign cfgBus.partial_powerdown_select  = st_reg.partial_powerdown_select;
  assign cfgBus.stop_instruction_enable = st_reg.stop_instruction_enable;

  pms_mode_decode u_decode (
    .cfg (cfgBus.dec)
  );

  assign mapped   = (paddr == `PMS_OFF_CTRL1) || (paddr == `PMS_OFF_CTRL2)
                    || (paddr == `PMS_OFF_STATUS);
  assign wrAcc    = psel & penable & pwrite;
  assign rdSetup  = psel & ~penable & ~pwrite;
  assign ackWrite = wrAcc & (paddr == `PMS_OFF_CTRL2) & pwdata[`PMS_C2_ACK_BIT];
  // Filtered wake pins are active low; timer interrupt wakes as well
  assign pinWake  = ~st_reg.filt[0] | ~st_reg.filt[1] | todIrq;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = st_reg.rdata;

  always_comb begin
    st_next              = st_reg;
    st_next.illegalPulse = 1'b0;
    st_next.porPulse     = 1'b0;
    // Three-stage pin synchroniser; a level counts once stages two and three agree
    st_next.s1 = {wakeIrqPinN, wakeResetPinN};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < 2; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.filt[i] = st_reg.s3[i];
      end
    end
    if (dbgLinkWrite) begin
      st_next.dbg = dbgLinkEnable;
    end
    case (st_reg.mode)
      PMS_M_RUN: begin
        if (stopStrobe) begin
          if (!st_reg.stop_instruction_enable) begin
            st_next.illegalPulse = 1'b1;
          end else if (cfgBus.stop2Allowed) begin
            st_next.mode   = PMS_M_PARTIAL_POWERDOWN_STOP;
            st_next.ioHold = 1'b1;
          end else begin
            st_next.mode   = PMS_M_RETENTION_STOP;
            st_next.fromLp = 1'b0;
          end
        end else if (waitStrobe) begin
          st_next.mode = PMS_M_WAIT;
        end else if (cfgBus.lpAllowed) begin
          st_next.mode = PMS_M_LOW_POWER_RUN;
        end
      end
      PMS_M_LOW_POWER_RUN: begin
        if (cpuResetEvent || !cfgBus.lpAllowed) begin
          st_next.mode = PMS_M_RUN;
        end else if (irqEvent && st_reg.wtfr) begin
          st_next.mode = PMS_M_RUN;
          st_next.low_power_run_request  = 1'b0;
        end else if (stopStrobe) begin
          if (!st_reg.stop_instruction_enable) begin
            st_next.illegalPulse = 1'b1;
          end else begin
            st_next.mode   = PMS_M_RETENTION_STOP;
            st_next.fromLp = 1'b1;
          end
        end else if (waitStrobe) begin
          st_next.mode = PMS_M_LOW_POWER_WAIT;
        end
      end
      PMS_M_WAIT: begin
        if (irqEvent || cpuResetEvent) begin
          st_next.mode = PMS_M_RUN;
        end
      end
      PMS_M_LOW_POWER_WAIT: begin
        if (cpuResetEvent) begin
          st_next.mode = PMS_M_RUN;
        end else if (irqEvent) begin
          if (st_reg.wtfr) begin
            st_next.mode = PMS_M_RUN;
            st_next.low_power_run_request  = 1'b0;
          end else begin
            st_next.mode = PMS_M_LOW_POWER_RUN;
          end
        end
      end
      PMS_M_RETENTION_STOP: begin
        if (cpuResetEvent) begin
          st_next.mode = PMS_M_RUN;
        end else if (irqEvent) begin
          if (st_reg.fromLp && !st_reg.wtfr) begin
            st_next.mode = PMS_M_LOW_POWER_RUN;
          end else begin
            st_next.mode = PMS_M_RUN;
            st_next.low_power_run_request  = st_reg.low_power_run_request & ~st_reg.fromLp;
          end
        end
      end
      PMS_M_PARTIAL_POWERDOWN_STOP: begin
        if (pinWake) begin
          st_next.mode     = PMS_M_RUN;
          st_next.porPulse = 1'b1;
        end
      end
      default: begin
        st_next.mode = PMS_M_RUN;
      end
    endcase
    if (wrAcc && paddr == `PMS_OFF_CTRL1) begin
      st_next.stop_instruction_enable = pwdata[`PMS_C1_STOP_INSTRUCTION_ENABLE_BIT];
      st_next.lowvolt_detect_enable  = pwdata[`PMS_C1_LOWVOLT_DETECT_ENABLE_BIT];
      st_next.lowvolt_detect_in_stop = pwdata[`PMS_C1_LOWVOLT_DETECT_IN_STOP_BIT];
    end
    if (wrAcc && paddr == `PMS_OFF_CTRL2) begin
      st_next.wtfr = pwdata[`PMS_C2_WTFR_BIT];
      st_next.partial_powerdown_select = pwdata[`PMS_C2_PARTIAL_POWERDOWN_SELECT_BIT] & ~st_reg.low_power_run_request;
      st_next.low_power_run_request  = pwdata[`PMS_C2_LPR_BIT] & ~st_reg.partial_powerdown_select
                     & ~(pwdata[`PMS_C2_PARTIAL_POWERDOWN_SELECT_BIT] & ~st_reg.low_power_run_request);
    end
    if (ackWrite) begin
      st_next.recov  = 1'b0;
      st_next.ioHold = 1'b0;
    end
    // A wake in the same cycle as an acknowledge keeps the flag set
    if (st_reg.mode == PMS_M_PARTIAL_POWERDOWN_STOP && pinWake) begin
      st_next.recov  = 1'b1;
      st_next.ioHold = 1'b1;
    end
    if (rdSetup) begin
      st_next.rdata = 32'h0;
      case (paddr)
        `PMS_OFF_CTRL1: begin
          st_next.rdata[`PMS_C1_STOP_INSTRUCTION_ENABLE_BIT] = st_reg.stop_instruction_enable;
          st_next.rdata[`PMS_C1_LOWVOLT_DETECT_ENABLE_BIT]  = st_reg.lowvolt_detect_enable;
          st_next.rdata[`PMS_C1_LOWVOLT_DETECT_IN_STOP_BIT] = st_reg.lowvolt_detect_in_stop;
        end
        `PMS_OFF_CTRL2: begin
          st_next.rdata[`PMS_C2_PARTIAL_POWERDOWN_SELECT_BIT] = st_reg.partial_powerdown_select;
          st_next.rdata[`PMS_C2_LPR_BIT]  = st_reg.low_power_run_request;
          st_next.rdata[`PMS_C2_WTFR_BIT] = st_reg.wtfr;
          st_next.rdata[`PMS_C2_FLAG_BIT] = st_reg.recov;
        end
        `PMS_OFF_STATUS: begin
          st_next.rdata[`PMS_ST_MODE_MSB:`PMS_ST_MODE_LSB] = st_reg.mode;
          st_next.rdata[`PMS_ST_DBG_BIT]    = st_reg.dbg;
          st_next.rdata[`PMS_ST_FROMLP_BIT] = st_reg.fromLp;
          st_next.rdata[`PMS_ST_HOLD_BIT]   = st_reg.ioHold;
        end
        default: begin
          st_next.rdata = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_reg              <= '0;
      st_reg.mode         <= PMS_M_RUN;
      st_reg.stop_instruction_enable        <= `PMS_RST_STOP_INSTRUCTION_ENABLE;
      st_reg.lowvolt_detect_enable         <= `PMS_RST_LOWVOLT_DETECT_ENABLE;
      st_reg.lowvolt_detect_in_stop        <= `PMS_RST_LOWVOLT_DETECT_IN_STOP;
      st_reg.partial_powerdown_select         <= `PMS_RST_PARTIAL_POWERDOWN_SELECT;
      st_reg.low_power_run_request          <= `PMS_RST_LPR;
      st_reg.wtfr         <= `PMS_RST_WTFR;
      st_reg.dbg          <= `PMS_RST_DBG;
      st_reg.s1           <= `PMS_RST_PINS;
      st_reg.s2           <= `PMS_RST_PINS;
      st_reg.s3           <= `PMS_RST_PINS;
      st_reg.filt         <= `PMS_RST_PINS;
    end else begin
      st_reg <= st_next;
    end
  end

  // Gating and regulator per mode
  always_comb begin
    cpuClkEn       = 1'b0;
    periphClkEn    = 1'b0;
    periphLowSpeed = 1'b0;
    clkGenBypassLp = 1'b0;
    debugClkEn     = 1'b0;
    refClkKeep     = 3'h7;
    domainPowerOff = 1'b0;
    regState       = PMS_REG_FULL;
    case (st_reg.mode)
      PMS_M_RUN: begin
        cpuClkEn    = 1'b1;
        periphClkEn = 1'b1;
        debugClkEn  = st_reg.dbg;
      end
      PMS_M_LOW_POWER_RUN: begin
        cpuClkEn       = 1'b1;
        periphClkEn    = 1'b1;
        periphLowSpeed = 1'b1;
        clkGenBypassLp = 1'b1;
        regState       = PMS_REG_STBY;
      end
      PMS_M_WAIT: begin
        periphClkEn = 1'b1;
        debugClkEn  = st_reg.dbg;
      end
      PMS_M_LOW_POWER_WAIT: begin
        periphClkEn    = 1'b1;
        periphLowSpeed = 1'b1;
        clkGenBypassLp = 1'b1;
        regState       = PMS_REG_STBY;
      end
      PMS_M_RETENTION_STOP: begin
        debugClkEn = st_reg.dbg;
        refClkKeep = clkGenStopEn;
        regState   = cfgBus.stopRegRaised ? PMS_REG_RAISED : PMS_REG_STBY;
      end
      PMS_M_PARTIAL_POWERDOWN_STOP: begin
        // Only the timer and display driver stay powered; oscillator optional
        domainPowerOff = 1'b1;
        refClkKeep     = {clkGenStopEn[2], 2'b00};
        regState       = PMS_REG_PPD;
      end
      default: begin
        regState = PMS_REG_FULL;
      end
    endcase
  end

  assign modeState      = st_reg.mode;
  assign ioLatchHold    = st_reg.ioHold;
  assign recoveryFlag   = st_reg.recov;
  assign illegalOpReset = st_reg.illegalPulse;
  assign porRestart     = st_reg.porPulse;

  a_partial_powerdown_stop_entry: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_reg.mode == PMS_M_RUN && stopStrobe && cfgBus.stop2Allowed)
    |=> (modeState == PMS_M_PARTIAL_POWERDOWN_STOP && regState == PMS_REG_PPD && domainPowerOff))
    else $error("stop did not reach partial powerdown");
  a_retention_stop_redirect: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_reg.mode == PMS_M_RUN && stopStrobe && st_reg.stop_instruction_enable && st_reg.partial_powerdown_select
     && (st_reg.dbg || (st_reg.lowvolt_detect_enable && st_reg.lowvolt_detect_in_stop)))
    |=> modeState == PMS_M_RETENTION_STOP)
    else $error("partial powerdown not redirected to retention");
  a_illegal_stop: assert property (@(posedge ref_clk) disable iff (!resetn)
    ((st_reg.mode == PMS_M_RUN || st_reg.mode == PMS_M_LOW_POWER_RUN) && stopStrobe && !st_reg.stop_instruction_enable)
    |=> (illegalOpReset && modeState != PMS_M_RETENTION_STOP && modeState != PMS_M_PARTIAL_POWERDOWN_STOP)
        ##1 !illegalOpReset)
    else $error("disabled stop not turned into illegal reset");
  a_run_to_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_reg.mode == PMS_M_RUN && waitStrobe && !stopStrobe)
    |=> (modeState == PMS_M_WAIT && !cpuClkEn && periphClkEn && !periphLowSpeed))
    else $error("wait from run went wrong");
  a_wait_exit: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_reg.mode == PMS_M_WAIT && (irqEvent || cpuResetEvent)) |=> modeState == PMS_M_RUN)
    else $error("wait not left on interrupt or reset");
  a_partial_powerdown_stop_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_reg.mode == PMS_M_PARTIAL_POWERDOWN_STOP && !pinWake) |=> modeState == PMS_M_PARTIAL_POWERDOWN_STOP)
    else $error("partial powerdown left without wake");
  a_partial_powerdown_stop_wake: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_reg.mode == PMS_M_PARTIAL_POWERDOWN_STOP && pinWake)
    |=> (modeState == PMS_M_RUN && porRestart && recoveryFlag && ioLatchHold)
        ##1 !porRestart)
    else $error("partial powerdown wake sequence wrong");
  a_flag_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_reg.recov && !ackWrite) |=> $stable(recoveryFlag) && ioLatchHold)
    else $error("recovery flag dropped without acknowledge");
  a_low_power_wait_back: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_reg.mode == PMS_M_LOW_POWER_WAIT && irqEvent && !cpuResetEvent && !st_reg.wtfr)
    |=> modeState == PMS_M_LOW_POWER_RUN)
    else $error("low-power wait did not return to low-power run");
  a_lp_full_wake: assert property (@(posedge ref_clk) disable iff (!resetn)
    ((st_reg.mode == PMS_M_LOW_POWER_WAIT || st_reg.mode == PMS_M_LOW_POWER_RUN) && irqEvent && st_reg.wtfr)
    |=> (modeState == PMS_M_RUN && !st_reg.low_power_run_request))
    else $error("interrupt did not force full run");
  a_lp_clocks: assert property (@(posedge ref_clk) disable iff (!resetn)
    (modeState == PMS_M_LOW_POWER_RUN)
    |-> (clkGenBypassLp && regState == PMS_REG_STBY && $past(cfgBus.lpAllowed)))
    else $error("low-power run without its conditions");
  a_dbg_full_run: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_reg.dbg [*2]) |-> (modeState != PMS_M_LOW_POWER_RUN && modeState != PMS_M_LOW_POWER_WAIT))
    else $error("low-power mode while debugging");
  a_mutex_bits: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(st_reg.low_power_run_request && st_reg.partial_powerdown_select))
    else $error("both low-power request and powerdown select set");
  a_retention_stop_wake: assert property (@(posedge ref_clk) disable iff (!resetn)
    (st_reg.mode == PMS_M_RETENTION_STOP && (cpuResetEvent || (irqEvent && !st_reg.fromLp)))
    |=> (modeState == PMS_M_RUN && cpuClkEn))
    else $error("retention stop did not return to run");

endmodule // pms_power_mode_selector
`default_nettype wire

// [common/pms_regs.svh]
// Purpose: Register offsets, field positions and reset values of the power mode selector
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

`define PMS_ADDR_W        8
`define PMS_DATA_W        32

`define PMS_OFF_CTRL1     8'h00
`define PMS_OFF_CTRL2     8'h04
`define PMS_OFF_STATUS    8'h08

// power_mgmt_ctrl_one fields
`define PMS_C1_STOP_INSTRUCTION_ENABLE_BIT  0
`define PMS_C1_LOWVOLT_DETECT_ENABLE_BIT   1
`define PMS_C1_LOWVOLT_DETECT_IN_STOP_BIT  2

// power_mgmt_ctrl_two fields
`define PMS_C2_PARTIAL_POWERDOWN_SELECT_BIT   0
`define PMS_C2_LPR_BIT    1
`define PMS_C2_WTFR_BIT   2
`define PMS_C2_ACK_BIT    3
`define PMS_C2_FLAG_BIT   4

// Status fields
`define PMS_ST_MODE_LSB   0
`define PMS_ST_MODE_MSB   2
`define PMS_ST_DBG_BIT    3
`define PMS_ST_FROMLP_BIT 4
`define PMS_ST_HOLD_BIT   5

`define PMS_RST_STOP_INSTRUCTION_ENABLE     1'b0
`define PMS_RST_LOWVOLT_DETECT_ENABLE      1'b0
`define PMS_RST_LOWVOLT_DETECT_IN_STOP     1'b0
`define PMS_RST_PARTIAL_POWERDOWN_SELECT      1'b0
`define PMS_RST_LPR       1'b0
`define PMS_RST_WTFR      1'b0
`define PMS_RST_DBG       1'b0
`define PMS_RST_PINS      2'h3

`endif

// [common/pms_pkg.sv]
// Purpose: Types shared by the power mode selector files
// Assumes: Nothing beyond the register header
// Notes:   Mode codes are the values seen in the status register
package pms_pkg;

  typedef enum logic [2:0] {
    PMS_M_RUN    = 3'b000,
    PMS_M_LOW_POWER_RUN  = 3'b001,
    PMS_M_WAIT   = 3'b010,
    PMS_M_LOW_POWER_WAIT = 3'b011,
    PMS_M_RETENTION_STOP  = 3'b100,
    PMS_M_PARTIAL_POWERDOWN_STOP  = 3'b101
  } pms_mode_t;

  typedef enum logic [1:0] {
    PMS_REG_FULL   = 2'b00,
    PMS_REG_STBY   = 2'b01,
    PMS_REG_RAISED = 2'b10,
    PMS_REG_PPD    = 2'b11
  } pms_regu_t;

  typedef struct packed {
    pms_mode_t   mode;
    logic        fromLp;
    logic        stop_instruction_enable;
    logic        lowvolt_detect_enable;
    logic        lowvolt_detect_in_stop;
    logic        partial_powerdown_select;
    logic        low_power_run_request;
    logic        wtfr;
    logic        dbg;
    logic        recov;
    logic        ioHold;
    logic        illegalPulse;
    logic        porPulse;
    logic [31:0] rdata;
    logic [1:0]  s1;
    logic [1:0]  s2;
    logic [1:0]  s3;
    logic [1:0]  filt;
  } pms_state_t;

endpackage

// [common/pms_cfg_if.sv]
// Purpose: Carries control bits to the mode decoder and its verdicts back
// Assumes: Both ends on the same clock
// Notes:   Purely combinational signals
`timescale 1ns/1ps
`default_nettype none
interface pms_cfg_if;
  logic dbgEn;
  logic lowvolt_detect_enable;
  logic lowvolt_detect_in_stop;
  logic low_power_run_request;
  logic partial_powerdown_select;
  logic stop_instruction_enable;
  logic bothLv;
  logic lpAllowed;
  logic stop2Allowed;
  logic stopRegRaised;
  modport ctl (output dbgEn, lowvolt_detect_enable, lowvolt_detect_in_stop, low_power_run_request, partial_powerdown_select, stop_instruction_enable,
               input  bothLv, lpAllowed, stop2Allowed, stopRegRaised);
  modport dec (input  dbgEn, lowvolt_detect_enable, lowvolt_detect_in_stop, low_power_run_request, partial_powerdown_select, stop_instruction_enable,
               output bothLv, lpAllowed, stop2Allowed, stopRegRaised);
endinterface
`default_nettype wire

// [core/pms_mode_decode.sv]
// Purpose: Decodes the control bits into the modes that may be entered
// Assumes: Inputs come from registers on the same clock
// Notes:   No state
`timescale 1ns/1ps
`default_nettype none
module pms_mode_decode (
  pms_cfg_if.dec cfg
);
  import pms_pkg::*;

  assign cfg.bothLv        = cfg.lowvolt_detect_enable & cfg.lowvolt_detect_in_stop;
  // Debug or stop-mode voltage detection pins the device to full run
  assign cfg.lpAllowed     = ~cfg.dbgEn & ~cfg.bothLv & cfg.low_power_run_request & ~cfg.partial_powerdown_select;
  // Otherwise stop lands in retention stop
  assign cfg.stop2Allowed  = cfg.stop_instruction_enable & ~cfg.dbgEn & ~cfg.bothLv
                             & ~cfg.low_power_run_request & cfg.partial_powerdown_select;
  assign cfg.stopRegRaised = cfg.bothLv | cfg.dbgEn;

endmodule // pms_mode_decode
`default_nettype wire

// [test/pms_cpu_model.sv]
// Purpose: CPU core model that issues instruction strobes and events
// Assumes: Every strobe is a one-cycle pulse on ref_clk
// Notes:   The bench drives it through the pulse task
`timescale 1ns/1ps
`default_nettype none
module pms_cpu_model (
  input  wire logic ref_clk,
  output logic      waitStrobe,
  output logic      stopStrobe,
  output logic      irqEvent,
  output logic      cpuResetEvent
);
  initial {waitStrobe, stopStrobe, irqEvent, cpuResetEvent} = 4'h0;
  // Raised after one edge and dropped after the next, so each event lasts exactly one cycle
  task automatic pulse(input logic [3:0] ev);
    @(posedge ref_clk);
    {waitStrobe, stopStrobe, irqEvent, cpuResetEvent} <= ev;
    @(posedge ref_clk);
    {waitStrobe, stopStrobe, irqEvent, cpuResetEvent} <= 4'h0;
  endtask
endmodule // pms_cpu_model
`default_nettype wire

// [test/tb.sv]
// Purpose: Self-checking bench of the power mode selector
// Assumes: Zero-wait APB slave, one-cycle mode answer to CPU strobes
// Notes:   Events to pulse(): 8 wait, 4 stop, 2 interrupt, 1 reset
`timescale 1ns/1ps
`default_nettype none
`include "pms_regs.svh"
module tb;
  import pms_pkg::*;
  logic        ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e, wS, sS, iE, rE, dbgLinkWrite = 1'b0, dbgLinkEnable = 1'b0;
  logic        wakeResetPinN = 1'b1, wakeIrqPinN = 1'b1, todIrq = 1'b0;
  logic        cpuClkEn, periphClkEn, periphLowSpeed, clkGenBypassLp;
  logic        debugClkEn, domainPowerOff, ioLatchHold, recoveryFlag, illegalOpReset, porRestart;
  logic [2:0]  clkGenStopEn = 3'h5, refClkKeep;
  pms_mode_t   modeState;
  pms_regu_t   regState;
  int          n_mismatch = 0, num_checks = 0;
  always #4 ref_clk = ~ref_clk;
  pms_cpu_model cpu (.ref_clk(ref_clk), .waitStrobe(wS), .stopStrobe(sS), .irqEvent(iE),
    .cpuResetEvent(rE));
  pms_power_mode_selector uut (.ref_clk(ref_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .waitStrobe(wS), .stopStrobe(sS), .irqEvent(iE), .cpuResetEvent(rE),
    .todIrq(todIrq), .dbgLinkWrite(dbgLinkWrite), .dbgLinkEnable(dbgLinkEnable),
    .wakeResetPinN(wakeResetPinN), .wakeIrqPinN(wakeIrqPinN), .clkGenStopEn(clkGenStopEn),
    .modeState(modeState), .regState(regState), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
    .periphLowSpeed(periphLowSpeed), .clkGenBypassLp(clkGenBypassLp), .debugClkEn(debugClkEn),
    .refClkKeep(refClkKeep), .domainPowerOff(domainPowerOff), .ioLatchHold(ioLatchHold),
    .recoveryFlag(recoveryFlag), .illegalOpReset(illegalOpReset), .porRestart(porRestart));
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic eq(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && i < 20) begin
      @(posedge ref_clk);
      i++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic t_wait();
    eq(modeState, PMS_M_RUN, "reset mode");
    eq({regState, cpuClkEn, periphClkEn, debugClkEn, refClkKeep}, 8'h37, "reset outs");
    cpu.pulse(4'h8);
    #1;
    eq(modeState, PMS_M_WAIT, "wait entry");
    eq({cpuClkEn, periphClkEn, periphLowSpeed, regState}, 5'h08, "wait clocks");
    cpu.pulse(4'h2);
    #1;
    eq(modeState, PMS_M_RUN, "irq exits wait");
    cpu.pulse(4'h8);
    cpu.pulse(4'h1);
    #1;
    eq(modeState, PMS_M_RUN, "reset exits wait");
    cpu.pulse(4'h4);
    #1;
    eq({modeState, illegalOpReset}, {PMS_M_RUN, 1'b1}, "stop disabled");
    cyc(1);
    eq(illegalOpReset, 1'b0, "illegal pulse width");
    $display("test wait done");
  endtask
  task automatic t_lowpower();
    apb(1'b1, `PMS_OFF_CTRL1, 32'h7);
    apb(1'b1, `PMS_OFF_CTRL2, 32'h2);
    cyc(2);
    eq(modeState, PMS_M_RUN, "both lv keep run");
    apb(1'b1, `PMS_OFF_CTRL2, 32'h0);
    apb(1'b1, `PMS_OFF_CTRL1, 32'h1);
    apb(1'b1, `PMS_OFF_CTRL2, 32'h2);
    cyc(2);
    eq({modeState, regState, clkGenBypassLp}, {PMS_M_LOW_POWER_RUN, PMS_REG_STBY, 1'b1}, "low_power_run");
    cpu.pulse(4'h8);
    #1;
    eq({modeState, cpuClkEn, periphLowSpeed}, {PMS_M_LOW_POWER_WAIT, 2'b01}, "low_power_wait");
    cpu.pulse(4'h2);
    #1;
    eq(modeState, PMS_M_LOW_POWER_RUN, "low_power_wait irq back");
    cpu.pulse(4'h4);
    #1;
    eq(modeState, PMS_M_RETENTION_STOP, "stop in low_power_run");
    eq({regState, refClkKeep, debugClkEn}, {PMS_REG_STBY, 3'h5, 1'b0}, "retention_stop outs");
    cpu.pulse(4'h2);
    #1;
    eq(modeState, PMS_M_LOW_POWER_RUN, "retention_stop irq back");
    apb(1'b1, `PMS_OFF_CTRL2, 32'h0);
    cyc(2);
    eq(modeState, PMS_M_RUN, "clear request");
    apb(1'b1, `PMS_OFF_CTRL2, 32'h6);
    cyc(2);
    cpu.pulse(4'h2);
    #1;
    eq(modeState, PMS_M_RUN, "wake to full run");
    apb(1'b1, `PMS_OFF_CTRL2, 32'h0);
    cyc(2);
    $display("test lowpower done");
  endtask
  task automatic t_partial_powerdown_stop();
    apb(1'b1, `PMS_OFF_CTRL2, 32'h1);
    apb(1'b1, `PMS_OFF_CTRL2, 32'h3);
    apb(1'b0, `PMS_OFF_CTRL2, 32'h0);
    eq(r[1:0], 2'b01, "request blocked");
    apb(1'b0, 8'h0c, 32'h0);
    eq({r, e}, 33'h1, "unmapped read");
    cpu.pulse(4'h4);
    #1;
    eq({modeState, regState}, {PMS_M_PARTIAL_POWERDOWN_STOP, PMS_REG_PPD}, "partial_powerdown_stop entry");
    eq({domainPowerOff, ioLatchHold, refClkKeep}, 5'h1c, "partial_powerdown_stop outs");
    cpu.pulse(4'h2);
    #1;
    eq(modeState, PMS_M_PARTIAL_POWERDOWN_STOP, "irq ignored");
    @(posedge ref_clk);
    wakeResetPinN <= 1'b0;
    for (int i = 0; i < 10 && modeState !== PMS_M_RUN; i++) cyc(1);
    eq({modeState, porRestart, recoveryFlag}, {PMS_M_RUN, 2'b11}, "pin wake");
    wakeResetPinN <= 1'b1;
    cyc(1);
    eq({porRestart, ioLatchHold}, 2'b01, "hold stays");
    cyc(5);
    cpu.pulse(4'h4);
    @(posedge ref_clk);
    wakeIrqPinN <= 1'b0;
    for (int i = 0; i < 10 && modeState !== PMS_M_RUN; i++) cyc(1);
    eq({modeState, porRestart}, {PMS_M_RUN, 1'b1}, "irq pin wake");
    @(posedge ref_clk);
    wakeIrqPinN <= 1'b1;
    cyc(5);
    cpu.pulse(4'h4);
    #1;
    eq(modeState, PMS_M_PARTIAL_POWERDOWN_STOP, "partial_powerdown_stop again");
    @(posedge ref_clk);
    todIrq <= 1'b1;
    @(posedge ref_clk);
    todIrq <= 1'b0;
    #1;
    eq({modeState, porRestart}, {PMS_M_RUN, 1'b1}, "timer wake");
    apb(1'b1, `PMS_OFF_CTRL2, 32'h9);
    eq({recoveryFlag, ioLatchHold}, 2'b00, "ack");
    cyc(5);
    $display("test partial_powerdown_stop done");
  endtask
  task automatic t_debug();
    apb(1'b1, `PMS_OFF_STATUS, 32'h8);
    @(posedge ref_clk);
    dbgLinkEnable <= 1'b1;
    dbgLinkWrite <= 1'b1;
    @(posedge ref_clk);
    dbgLinkWrite <= 1'b0;
    clkGenStopEn <= 3'h2;
    apb(1'b0, `PMS_OFF_STATUS, 32'h0);
    eq(r[`PMS_ST_DBG_BIT], 1'b1, "link sets debug");
    cpu.pulse(4'h4);
    #1;
    eq(modeState, PMS_M_RETENTION_STOP, "debug blocks partial_powerdown_stop");
    eq({regState, debugClkEn, refClkKeep}, {PMS_REG_RAISED, 1'b1, 3'h2}, "debug retention_stop");
    cpu.pulse(4'h2);
    #1;
    eq(modeState, PMS_M_RUN, "retention_stop irq to run");
    $display("test debug done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    cyc(2);
    t_wait();
    t_lowpower();
    t_partial_powerdown_stop();
    t_debug();
    close_out();
  end
  initial begin
    #100us;
    eq(1'b0, 1'b1, "timeout");
    close_out();
  end
endmodule // tb
`default_nettype wire
